// ### core/pism_pkg.sv
// Constants and types for the front-panel input setup menu.
// Assumes a single 100 MHz system clock; all timing is counted in ms ticks.
package pism_pkg;

  // Clock and base tick
  localparam int SYS_CLK_NS    = 10;
  localparam int TICK_NS       = 1_000_000;
  localparam int TICK_CYCLES   = TICK_NS / SYS_CLK_NS;

  // Operator timing, in ms of the base tick
  localparam int SEGTEST_MS    = 1000;
  localparam int ENTRY_HOLD_MS = 2000;
  localparam int REPEAT_HOLD_MS = 1000;
  localparam int FAST_AFTER_MS = 2000;
  localparam int SLOW_STEP_MS  = 250;
  localparam int FAST_STEP_MS  = 50;
  localparam int TIMEOUT_S     = 60;
  localparam int TIMEOUT_MS    = TIMEOUT_S * 1000;

  // Millisecond counter width
  localparam int MS_W          = 16;

  // Measurement type codes, cycled by up and down
  localparam logic [1:0] TYPE_MEASURE_A        = 2'h0;
  localparam logic [1:0] TYPE_MEASURE_ROTATION = 2'h1;
  localparam logic [1:0] TYPE_COUNT_UPWARD     = 2'h2;
  localparam logic [1:0] TYPE_COUNT_DOWNWARD   = 2'h3;
  localparam logic [1:0] TYPE_TOP              = 2'h3;

  // Sensing mode codes
  localparam logic [1:0] SENSE_LOGIC_LEVEL     = 2'h0;
  localparam logic [1:0] SENSE_SINK_CONTACT    = 2'h1;
  localparam logic [1:0] SENSE_SOURCE_CONTACT  = 2'h2;
  localparam logic [1:0] SENSE_TOP             = 2'h2;

  // Reset values of the active settings
  localparam logic [1:0] TYPE_RESET            = TYPE_MEASURE_A;
  localparam logic [1:0] SENSE_RESET           = SENSE_LOGIC_LEVEL;

  // Input bit positions in the synchroniser vectors
  localparam int IN_SELECT = 0;
  localparam int IN_UP     = 1;
  localparam int IN_DOWN   = 2;
  localparam int IN_CLEAR  = 3;

  typedef enum logic [2:0] {
    ST_SEGTEST,
    ST_RUN,
    ST_TYPE_PROMPT,
    ST_TYPE_EDIT,
    ST_SENSE_PROMPT,
    ST_SENSE_EDIT
  } pism_state_t;

  typedef enum logic [3:0] {
    DSP_SEGTEST,
    DSP_MEASURE,
    DSP_TYPE_PROMPT,
    DSP_MEASURE_A,
    DSP_MEASURE_ROTATION,
    DSP_COUNT_UPWARD,
    DSP_COUNT_DOWNWARD,
    DSP_SENSE_PROMPT,
    DSP_LOGIC_LEVEL,
    DSP_SINK_CONTACT,
    DSP_SOURCE_CONTACT
  } pism_disp_t;

endpackage : pism_pkg

// ### core/pism_setup.sv
// Front-panel setup menu: measurement type and input sensing mode.
// Assumes raw active-high buttons and an active-low counter-clear pin,
// all asynchronous to sys_clk; parameter menus sit downstream.
//
// Behaviour
// - Sink contact mode turns the internal pull-up on.
// - Source contact mode turns the internal pull-down on.
// - Counter clear pin held low clears the current count.
// - Sixty idle seconds in configuration abort it, dropping all edits.
// - One press of up adds one, one press of down subtracts one.
// - Holding up or down over a second repeats, later faster.
// - Stepping past either end of a range wraps to the other end.
// - Segment test runs after power-on before configuration can start.
// - Holding up over two seconds enters configuration at type prompt.
// - At type prompt up and down cycle four measurement types.
// - Switching to rotation restores range settings to factory defaults.
// - Select keeps the edited type and shows the type prompt again; nothing becomes active yet.
// - Another select advances to the sensing mode prompt.
// - At sensing prompt up and down cycle three sensing modes.
// - Select keeps the edited sensing mode and shows its prompt again; a further select commits both.
// - Then the parameter sequence of the committed type follows.
// - On clear release the counter restarts at zero or upper value.

`timescale 1ns/100ps
`default_nettype none

module pism_setup
  import pism_pkg::*;
#(
  parameter int CLK_PER_TICK = TICK_CYCLES,
  parameter int TIMEOUT_TICKS = TIMEOUT_MS,
  parameter int SEGTEST_TICKS = SEGTEST_MS,
  parameter int ENTRY_TICKS = ENTRY_HOLD_MS,
  parameter int REPEAT_TICKS = REPEAT_HOLD_MS,
  parameter int FAST_TICKS = FAST_AFTER_MS,
  parameter int SLOW_PERIOD = SLOW_STEP_MS,
  parameter int FAST_PERIOD = FAST_STEP_MS
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       btn_select,
  input  wire logic       btn_up,
  input  wire logic       btn_down,
  input  wire logic       count_clear_n,
  output logic            in_config,
  output pism_disp_t      disp_item,
  output logic [1:0]      active_type,
  output logic [1:0]      active_sense,
  output logic            pull_up_en,
  output logic            pull_down_en,
  output logic            count_clear,
  output logic            count_restart,
  output logic            count_from_top,
  output logic            defaults_restore,
  output logic            param_start,
  output logic [1:0]      param_type
);

  localparam int TICK_W = $clog2(CLK_PER_TICK + 1);

  // Refuse settings the counters cannot hold
  if (CLK_PER_TICK < 2 || TIMEOUT_TICKS >= (1 << MS_W) ||
      SEGTEST_TICKS >= (1 << MS_W) || ENTRY_TICKS >= (1 << MS_W) ||
      REPEAT_TICKS + FAST_TICKS >= (1 << MS_W) || SLOW_PERIOD < 1 ||
      FAST_PERIOD < 1 || SLOW_PERIOD >= (1 << MS_W)) begin : g_bad_param
    $error("pism_setup: parameter out of range");
  end

  typedef struct packed {
    pism_state_t       state;
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        prev;
    logic [TICK_W-1:0] tick_cnt;
    logic [MS_W-1:0]   phase_ms;
    logic [MS_W-1:0]   idle_ms;
    logic [MS_W-1:0]   hold_ms;
    logic [MS_W-1:0]   rep_ms;
    logic              wait_release;
    logic [1:0]        edit_type;
    logic [1:0]        edit_sense;
    logic [1:0]        act_type;
    logic [1:0]        act_sense;
    logic              clear;
    logic              restart;
    logic              restore;
    logic              pstart;
    logic [1:0]        ptype;
    pism_disp_t        disp;
  } pism_reg_t;

  localparam pism_reg_t REG_RESET = '{
    state:    ST_SEGTEST,
    act_type: TYPE_RESET,
    act_sense: SENSE_RESET,
    disp:     DSP_SEGTEST,
    default:  '0
  };

  // Cyclic step with wraparound at both ends
  function automatic logic [1:0] step_wrap(input logic [1:0] v,
                                           input logic       up,
                                           input logic [1:0] top);
    if (up) begin
      step_wrap = (v == top) ? 2'h0 : v + 2'h1;
    end else begin
      step_wrap = (v == 2'h0) ? top : v - 2'h1;
    end
  endfunction : step_wrap

  // Saturating ms counter increment
  function automatic logic [MS_W-1:0] sat_inc(input logic [MS_W-1:0] v);
    sat_inc = (&v) ? v : v + {{(MS_W-1){1'b0}}, 1'b1};
  endfunction : sat_inc

  logic      rst_meta;
  logic      rst_sync_n;
  pism_reg_t r;
  pism_reg_t next_r;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    logic       tick;
    logic       sel_press;
    logic       held;
    logic       dir_up;
    logic       edge_now;
    logic       step;
    logic [MS_W-1:0] period;
    tick      = 1'b0;
    sel_press = 1'b0;
    held      = 1'b0;
    dir_up    = 1'b0;
    edge_now  = 1'b0;
    step      = 1'b0;
    period    = '0;
    next_r = r;
    next_r.restart = 1'b0;
    next_r.restore = 1'b0;
    next_r.pstart  = 1'b0;

    // Clear pin is inverted before sampling so idle reads as zero
    next_r.sync1 = {~count_clear_n, btn_down, btn_up, btn_select};
    next_r.sync2 = r.sync1;
    next_r.prev  = r.sync2;

    // Base ms tick from the system clock
    tick = (r.tick_cnt == TICK_W'(CLK_PER_TICK - 1));
    next_r.tick_cnt = tick ? '0 : r.tick_cnt + TICK_W'(1);

    sel_press = r.sync2[IN_SELECT] & ~r.prev[IN_SELECT];
    held      = r.sync2[IN_UP] | r.sync2[IN_DOWN];
    dir_up    = r.sync2[IN_UP];  // Up wins when both are held
    edge_now  = dir_up ? ~r.prev[IN_UP]
                       : (~r.prev[IN_DOWN] | r.prev[IN_UP]);

    // Clear level and restart pulse on release
    next_r.clear   = r.sync2[IN_CLEAR];
    next_r.restart = r.prev[IN_CLEAR] & ~r.sync2[IN_CLEAR];

    // Press, hold and auto-repeat timing for up and down
    step = 1'b0;
    period = (r.hold_ms >= MS_W'(REPEAT_TICKS + FAST_TICKS))
           ? MS_W'(FAST_PERIOD) : MS_W'(SLOW_PERIOD);
    if (!held) begin
      next_r.hold_ms = '0;
      next_r.rep_ms  = '0;
      next_r.wait_release = 1'b0;
    end else if (edge_now) begin
      step = ~r.wait_release;
      next_r.hold_ms = '0;
      next_r.rep_ms  = '0;
    end else if (tick) begin
      next_r.hold_ms = sat_inc(r.hold_ms);
      if (r.hold_ms >= MS_W'(REPEAT_TICKS)) begin
        if (r.rep_ms >= period - MS_W'(1)) begin
          next_r.rep_ms = '0;
          step = ~r.wait_release;
        end else begin
          next_r.rep_ms = r.rep_ms + MS_W'(1);
        end
      end
    end

    // Inactivity timer restarts on any held button
    if (held || r.sync2[IN_SELECT]) begin
      next_r.idle_ms = '0;
    end else if (tick) begin
      next_r.idle_ms = sat_inc(r.idle_ms);
    end

    unique case (r.state)
      ST_SEGTEST: begin
        // Buttons are ignored until the segment test is over
        if (tick) begin
          next_r.phase_ms = sat_inc(r.phase_ms);
        end
        if (r.phase_ms >= MS_W'(SEGTEST_TICKS)) begin
          next_r.state = ST_RUN;
        end
      end
      ST_RUN: begin
        // Entry hold; the continued hold must not step or repeat until the button is released
        if (r.sync2[IN_UP] && r.hold_ms >= MS_W'(ENTRY_TICKS)) begin
          next_r.state = ST_TYPE_PROMPT;
          next_r.edit_type  = r.act_type;
          next_r.edit_sense = r.act_sense;
          next_r.wait_release = 1'b1;
        end
      end
      ST_TYPE_PROMPT, ST_TYPE_EDIT: begin
        if (step) begin
          next_r.state = ST_TYPE_EDIT;
          next_r.edit_type = step_wrap(r.edit_type, dir_up,
                                       TYPE_TOP);
        end else if (sel_press && r.state == ST_TYPE_EDIT) begin
          next_r.state = ST_TYPE_PROMPT;
        end else if (sel_press) begin
          next_r.state = ST_SENSE_PROMPT;
        end
      end
      ST_SENSE_PROMPT, ST_SENSE_EDIT: begin
        if (step) begin
          next_r.state = ST_SENSE_EDIT;
          next_r.edit_sense = step_wrap(r.edit_sense, dir_up,
                                        SENSE_TOP);
        end else if (sel_press && r.state == ST_SENSE_EDIT) begin
          next_r.state = ST_SENSE_PROMPT;
        end else if (sel_press) begin
          // Session completes: edits become active, parameter menu of the committed type follows
          next_r.state     = ST_RUN;
          next_r.act_type  = r.edit_type;
          next_r.act_sense = r.edit_sense;
          next_r.pstart    = 1'b1;
          next_r.ptype     = r.edit_type;
          next_r.restore   = (r.edit_type == TYPE_MEASURE_ROTATION) &&
                             (r.act_type != TYPE_MEASURE_ROTATION);
        end
      end
    endcase

    // Timeout drops the session and leaves active settings alone, unless a select commits in the same cycle
    if (r.state != ST_SEGTEST && r.state != ST_RUN &&
        r.idle_ms >= MS_W'(TIMEOUT_TICKS)) begin
      next_r.state      = ST_RUN;
      next_r.edit_type  = r.act_type;
      next_r.edit_sense = r.act_sense;
    end

    // Display item follows the next state
    unique case (next_r.state)
      ST_SEGTEST:      next_r.disp = DSP_SEGTEST;
      ST_RUN:          next_r.disp = DSP_MEASURE;
      ST_TYPE_PROMPT:  next_r.disp = DSP_TYPE_PROMPT;
      ST_SENSE_PROMPT: next_r.disp = DSP_SENSE_PROMPT;
      ST_TYPE_EDIT: begin
        unique case (next_r.edit_type)
          TYPE_MEASURE_A:        next_r.disp = DSP_MEASURE_A;
          TYPE_MEASURE_ROTATION: next_r.disp = DSP_MEASURE_ROTATION;
          TYPE_COUNT_UPWARD:     next_r.disp = DSP_COUNT_UPWARD;
          default:               next_r.disp = DSP_COUNT_DOWNWARD;
        endcase
      end
      ST_SENSE_EDIT: begin
        unique case (next_r.edit_sense)
          SENSE_SINK_CONTACT:   next_r.disp = DSP_SINK_CONTACT;
          SENSE_SOURCE_CONTACT: next_r.disp = DSP_SOURCE_CONTACT;
          default:              next_r.disp = DSP_LOGIC_LEVEL;
        endcase
      end
      default:         next_r.disp = DSP_MEASURE;
    endcase
  end

  // Single state register
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r <= REG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign in_config        = (r.state != ST_SEGTEST) && (r.state != ST_RUN);
  assign disp_item        = r.disp;
  assign active_type      = r.act_type;
  assign active_sense     = r.act_sense;
  assign count_clear      = r.clear;
  assign count_restart    = r.restart;
  assign defaults_restore = r.restore;
  assign param_start      = r.pstart;
  assign param_type       = r.ptype;

  // Pull selection follows only the committed mode; logic level has none
  assign pull_up_en   = (r.act_sense == SENSE_SINK_CONTACT);
  assign pull_down_en = (r.act_sense == SENSE_SOURCE_CONTACT);
  assign count_from_top = (r.act_type == TYPE_COUNT_DOWNWARD);

endmodule : pism_setup

`default_nettype wire

// ### tb/pism_xducer.sv
// Pulse transducer model: a contact to ground or to supply on the input.
// Assumes the pull enables come from the setup block under test.
`timescale 1ns/100ps
`default_nettype none
module pism_xducer (
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  input  wire logic sink_kind,
  input  wire logic closed,
  input  wire logic drive_lvl,
  output logic      pin
);
  // An open contact leaves the line to the internal pull; with no pull,
  // the source must drive it actively or the level is undefined
  always_comb begin
    if (closed) pin = !sink_kind;
    else if (pull_up_en) pin = 1'h1;
    else if (pull_down_en) pin = 1'h0;
    else pin = drive_lvl;
  end
endmodule : pism_xducer
`default_nettype wire

// ### tb/pism_setup_checker.sv
// Concurrent checks on the setup menu ports.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/100ps
`default_nettype none
module pism_setup_checker
  import pism_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       count_clear_n,
  input wire logic       in_config,
  input wire pism_disp_t disp_item,
  input wire logic [1:0] active_type,
  input wire logic [1:0] active_sense,
  input wire logic       pull_up_en,
  input wire logic       pull_down_en,
  input wire logic       count_clear,
  input wire logic       count_restart,
  input wire logic       count_from_top,
  input wire logic       defaults_restore,
  input wire logic       param_start,
  input wire logic [1:0] param_type
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Pull enables follow the committed sensing mode only
  pull_up_a: assert property (pull_up_en == (active_sense == 2'h1))
    else $error("pull-up enable wrong");
  pull_down_a: assert property (pull_down_en == (active_sense == 2'h2))
    else $error("pull-down enable wrong");
  // Six cycles cover the synchroniser lag, also just after reset
  clear_hold_a: assert property (!count_clear_n [*6] |-> count_clear)
    else $error("clear not applied");
  restart_pulse_a: assert property (count_restart |-> $past(count_clear) && !count_clear)
    else $error("restart without clear release");
  from_top_a: assert property (count_from_top == (active_type == TYPE_COUNT_DOWNWARD))
    else $error("restart point wrong");
  commit_only_a: assert property (!param_start |-> $stable(active_type) && $stable(active_sense))
    else $error("settings changed outside commit");
  end_start_a: assert property (param_start |-> $fell(in_config) && param_type == active_type)
    else $error("hand-off wrong");
  rot_default_a: assert property (defaults_restore |-> param_start && active_type == TYPE_MEASURE_ROTATION && $past(active_type) != TYPE_MEASURE_ROTATION)
    else $error("defaults restore wrong");
  entry_prompt_a: assert property ($rose(in_config) |-> disp_item == DSP_TYPE_PROMPT)
    else $error("entry prompt wrong");
endmodule : pism_setup_checker
`default_nettype wire

bind pism_setup pism_setup_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .count_clear_n(count_clear_n), .in_config(in_config), .disp_item(disp_item),
  .active_type(active_type), .active_sense(active_sense),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
  .count_clear(count_clear), .count_restart(count_restart),
  .count_from_top(count_from_top), .defaults_restore(defaults_restore),
  .param_start(param_start), .param_type(param_type));

// ### tb/tb.sv
// Self-checking bench: drives buttons and the clear pin, queues expected
// display items. Assumes shortened tick and hold counts.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pism_pkg::*;
  logic       sys_clk, resetn, btn_select, btn_up, btn_down, count_clear_n;
  logic       in_config, pull_up_en, pull_down_en, count_clear, count_restart;
  logic       count_from_top, defaults_restore, param_start, pin;
  logic       sink_kind, closed, drive_lvl;
  logic [1:0] active_type, active_sense, param_type;
  pism_disp_t disp_item, last;
  pism_disp_t note_q[$];
  int         fails, total_checks, cycles, restarts, restores, changes, t, s;
  bit         free;

  // Shortened timing so a whole menu walk fits in a few thousand cycles
  localparam int TB_TICK    = 4;
  localparam int TB_TIMEOUT = 40;
  localparam int TB_SEGTEST = 3;
  localparam int TB_ENTRY   = 5;
  localparam int TB_REPEAT  = 4;
  localparam int TB_FAST    = 6;
  localparam int TB_SLOW_P  = 3;
  localparam int TB_FAST_P  = 1;

  pism_setup #(.CLK_PER_TICK(TB_TICK), .TIMEOUT_TICKS(TB_TIMEOUT),
    .SEGTEST_TICKS(TB_SEGTEST), .ENTRY_TICKS(TB_ENTRY),
    .REPEAT_TICKS(TB_REPEAT), .FAST_TICKS(TB_FAST),
    .SLOW_PERIOD(TB_SLOW_P), .FAST_PERIOD(TB_FAST_P))
    dut (.sys_clk(sys_clk), .resetn(resetn),
    .btn_select(btn_select), .btn_up(btn_up), .btn_down(btn_down),
    .count_clear_n(count_clear_n), .in_config(in_config),
    .disp_item(disp_item), .active_type(active_type),
    .active_sense(active_sense), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .count_clear(count_clear),
    .count_restart(count_restart), .count_from_top(count_from_top),
    .defaults_restore(defaults_restore), .param_start(param_start),
    .param_type(param_type));

  pism_xducer u_src (.pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .sink_kind(sink_kind), .closed(closed), .drive_lvl(drive_lvl),
    .pin(pin));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // A hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 4000) begin
      fails++;
      give_verdict();
    end
  end

  // Each display change takes the oldest note; in free mode only counted.
  // Sampled on the falling edge so registered outputs have settled.
  always @(negedge sys_clk) begin
    restarts += (count_restart === 1'h1);
    restores += (defaults_restore === 1'h1);
    if (disp_item !== last && free) changes++;
    else if (disp_item !== last) begin
      total_checks++;
      if (note_q.size() == 0 || note_q[0] !== disp_item) begin
        fails++;
        $display("CHECK FAILED %0t display item %0d", $time, disp_item);
      end
      if (note_q.size() != 0) void'(note_q.pop_front());
    end
    last = disp_item;
  end

  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'h1) begin
      fails++;
      $display("CHECK FAILED %0t output value", $time);
    end
  endtask : chk

  // Hold one button n cycles; inputs move 1 ns after the edge
  task automatic press(input int b, input int n, input pism_disp_t d);
    if (!free) note_q.push_back(d);
    {btn_down, btn_up, btn_select} = 3'h1 << b;
    repeat (n) @(posedge sys_clk);
    #1 {btn_down, btn_up, btn_select} = 3'h0;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : press

  // One step with wrap at both ends of 0..top
  task automatic step(input bit up, inout int v, input int top,
                      input pism_disp_t base);
    v = up ? (v == top ? 0 : v + 1) : (v == 0 ? top : v - 1);
    press(up ? IN_UP : IN_DOWN, 2, pism_disp_t'(base + v));
  endtask : step

  task automatic give_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  initial begin
    {btn_down, btn_up, btn_select} = 3'h0;
    count_clear_n = 1'h1;
    resetn = 1'h0;
    sink_kind = 1'h1;
    closed = 1'h0;
    last = DSP_SEGTEST;
    void'($urandom(75487));
    drive_lvl = 1'($urandom);
    note_q.push_back(DSP_MEASURE);
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1'h1;
    btn_up = 1'h1; // ignored while the segment test runs
    repeat (3) @(posedge sys_clk);
    #1 btn_up = 1'h0;
    chk(disp_item === DSP_SEGTEST && in_config === 1'h0);
    chk(!pull_up_en && !pull_down_en && pin === drive_lvl);
    repeat (30) @(posedge sys_clk);
    #1 press(IN_UP, 40, DSP_TYPE_PROMPT);
    chk(in_config === 1'h1);
    for (int i = 0; i < 5; i++) step(1'(5'h0e >> i), t, 3, DSP_MEASURE_A);
    press(IN_SELECT, 2, DSP_TYPE_PROMPT);
    press(IN_SELECT, 2, DSP_SENSE_PROMPT);
    for (int i = 0; i < 5; i++) step(1'(5'h07 >> i), s, 2, DSP_LOGIC_LEVEL);
    press(IN_SELECT, 2, DSP_SENSE_PROMPT);
    chk(active_type === TYPE_RESET);
    press(IN_SELECT, 2, DSP_MEASURE);
    chk(active_type === TYPE_MEASURE_ROTATION);
    chk(active_sense === SENSE_SINK_CONTACT && pin === 1'h1);
    chk(param_type === 2'h1 && restores == 1);
    // Auto-repeat counted by display changes, then the idle abort
    press(IN_UP, 40, DSP_TYPE_PROMPT);
    free = 1'h1;
    changes = 0;
    // Long enough for the first slow repeat at any tick phase, too short
    // for the second one
    press(IN_DOWN, 36, DSP_MEASURE);
    chk(changes >= 2 && changes <= 3);
    changes = 0;
    press(IN_DOWN, 100, DSP_MEASURE);
    chk(changes >= 12);
    free = 1'h0;
    note_q.push_back(DSP_MEASURE);
    repeat (200) @(posedge sys_clk);
    #1 chk(in_config === 1'h0 && active_type === 2'h1);
    // Second session: down counter with source contact
    t = 1;
    s = 1;
    press(IN_UP, 40, DSP_TYPE_PROMPT);
    for (int i = 0; i < 2; i++) step(1'h0, t, 3, DSP_MEASURE_A);
    press(IN_SELECT, 2, DSP_TYPE_PROMPT);
    press(IN_SELECT, 2, DSP_SENSE_PROMPT);
    step(1'h1, s, 2, DSP_LOGIC_LEVEL);
    press(IN_SELECT, 2, DSP_SENSE_PROMPT);
    press(IN_SELECT, 2, DSP_MEASURE);
    sink_kind = 1'h0;
    #1 chk(pull_down_en === 1'h1 && pull_up_en === 1'h0 && pin === 1'h0);
    chk(count_from_top === 1'h1 && restores == 1);
    // A closed source contact must still pull the line to supply
    closed = 1'h1;
    #1 chk(pin === 1'h1 && pull_up_en === 1'h0);
    closed = 1'h0;
    @(posedge sys_clk);
    #1;
    // Clear pin held low for random lengths
    for (int i = 0; i < 3; i++) begin
      count_clear_n = 1'h0;
      repeat (4 + $urandom % 16) @(posedge sys_clk);
      #1 chk(count_clear === 1'h1);
      count_clear_n = 1'h1;
      repeat (6) @(posedge sys_clk);
      #1 chk(count_clear === 1'h0);
    end
    chk(restarts == 3 && note_q.size() == 0);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
